// *** rtl/sxs_core.sv ***
/*
 * Execution block for subtract, xor, nibble swap, direction load and sleep,
 * reached as an APB slave. A write to the command register runs one operation
 * in the following cycle. Assumes the file operand is placed in the file
 * register by software before the command and the result read back after.
 */
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module sxs_core
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core side
   input wire logic wake_req,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction,
   output logic osc_stop
);
   // Register state
   logic [7:0] acc_q;
   logic [7:0] file_q;
   logic [7:0] dir_a_q;
   logic [7:0] dir_b_q;
   logic [7:0] dir_c_q;
   logic carry_q;
   logic nibble_carry_flag_q;
   logic zero_q;
   logic timeout_status_bit_q;
   logic powerdown_status_bit_q;
   logic sleep_q;
   // Latched command
   sxs_pkg::sxs_op_t op_q;
   logic dest_q;
   logic [7:0] lit_q;
   logic exec_q;
   logic [15:0] cmd_word_q;
   // Bus outputs
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   // Bus decode
   logic wr_en;
   logic mapped;
   logic [31:0] rd_mux;
   // Datapath results
   logic [7:0] alu_result;
   logic alu_carry;
   logic alu_nibble;
   logic alu_zero;
   logic alu_arith_upd;
   logic alu_zero_upd;
   logic run;
   logic wdog_clear;
   logic wdog_expire;
   logic [7:0] wdog_count;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Write happens at the access edge only
   assign wr_en = psel && penable && pwrite && pready_q;
   // Operation runs only while awake
   assign run = exec_q && !sleep_q;
   assign wdog_clear = run && (op_q == sxs_pkg::OP_SLEEP);

   // Address map check: aligned words up to the watchdog register
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= sxs_pkg::ADDR_WDOG);

   // Read data selection, upper bits zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         sxs_pkg::ADDR_CMD: rd_mux = {16'h0000, cmd_word_q};
         sxs_pkg::ADDR_ACC: rd_mux = {24'h00_0000, acc_q};
         sxs_pkg::ADDR_FILE: rd_mux = {24'h00_0000, file_q};
         sxs_pkg::ADDR_STATUS:
         begin
            rd_mux[sxs_pkg::ST_CARRY] = carry_q;
            rd_mux[sxs_pkg::ST_NIBBLE] = nibble_carry_flag_q;
            rd_mux[sxs_pkg::ST_ZERO] = zero_q;
            rd_mux[sxs_pkg::ST_POWERDOWN] = powerdown_status_bit_q;
            rd_mux[sxs_pkg::ST_TIMEOUT] = timeout_status_bit_q;
            rd_mux[sxs_pkg::ST_SLEEP] = sleep_q;
         end
         sxs_pkg::ADDR_DIR_A: rd_mux = {24'h00_0000, dir_a_q};
         sxs_pkg::ADDR_DIR_B: rd_mux = {24'h00_0000, dir_b_q};
         sxs_pkg::ADDR_DIR_C: rd_mux = {24'h00_0000, dir_c_q};
         sxs_pkg::ADDR_WDOG: rd_mux = {24'h00_0000, wdog_count};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: ready, data and error set on the setup edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (psel && !penable)
      begin
         // Zero wait states
         pready_q <= 1'b1;
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_q <= !mapped;
      end
      else
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command capture; exec pulses one cycle after the write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_q <= sxs_pkg::OP_NONE;
         dest_q <= 1'b0;
         lit_q <= 8'h00;
         exec_q <= 1'b0;
         cmd_word_q <= 16'h0000;
      end
      else if (wr_en && (paddr == sxs_pkg::ADDR_CMD))
      begin
         op_q <= sxs_pkg::sxs_op_t'(pwdata[sxs_pkg::CMD_OP_LSB +: 4]);
         dest_q <= pwdata[sxs_pkg::CMD_DEST_BIT];
         lit_q <= pwdata[sxs_pkg::CMD_LIT_LSB +: 8];
         exec_q <= 1'b1;
         cmd_word_q <= pwdata[15:0];
      end
      else
         exec_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Datapath
   sxs_alu u_alu
   (
      .op(op_q),
      .acc(acc_q),
      .file(file_q),
      .lit(lit_q),
      .carry_in(carry_q),
      .result(alu_result),
      .carry_out(alu_carry),
      .nibble_out(alu_nibble),
      .zero_out(alu_zero),
      .arith_upd(alu_arith_upd),
      .zero_upd(alu_zero_upd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator: software write or operation result
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_q <= sxs_pkg::ACC_RESET;
      else if (wr_en && (paddr == sxs_pkg::ADDR_ACC))
         acc_q <= pwdata[7:0];
      else if (run)
      begin
         case (op_q)
            // Literal forms always land in the accumulator
            sxs_pkg::OP_LIT_SUB, sxs_pkg::OP_XOR_LIT:
               acc_q <= alu_result;
            // Destination bit clear picks accumulator
            sxs_pkg::OP_FILE_SUB, sxs_pkg::OP_FILE_SUB_BORROW,
            sxs_pkg::OP_NIBBLE_SWAP, sxs_pkg::OP_XOR_FILE:
               if (!dest_q)
                  acc_q <= alu_result;
            default:
               acc_q <= acc_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // File operand: software write or result with destination bit set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         file_q <= sxs_pkg::FILE_RESET;
      else if (wr_en && (paddr == sxs_pkg::ADDR_FILE))
         file_q <= pwdata[7:0];
      else if (run && dest_q)
      begin
         case (op_q)
            sxs_pkg::OP_FILE_SUB, sxs_pkg::OP_FILE_SUB_BORROW,
            sxs_pkg::OP_NIBBLE_SWAP, sxs_pkg::OP_XOR_FILE:
               file_q <= alu_result;
            default:
               file_q <= file_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic flags: operation wins over software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         carry_q <= 1'b0;
         nibble_carry_flag_q <= 1'b0;
         zero_q <= 1'b0;
      end
      else
      begin
         if (run && alu_arith_upd)
         begin
            carry_q <= alu_carry;
            nibble_carry_flag_q <= alu_nibble;
         end
         else if (wr_en && (paddr == sxs_pkg::ADDR_STATUS))
         begin
            carry_q <= pwdata[sxs_pkg::ST_CARRY];
            nibble_carry_flag_q <= pwdata[sxs_pkg::ST_NIBBLE];
         end
         // Zero flag follows the same priority
         if (run && alu_zero_upd)
            zero_q <= alu_zero;
         else if (wr_en && (paddr == sxs_pkg::ADDR_STATUS))
            zero_q <= pwdata[sxs_pkg::ST_ZERO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direction registers, loaded by operand value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_a_q <= sxs_pkg::DIR_RESET;
         dir_b_q <= sxs_pkg::DIR_RESET;
         dir_c_q <= sxs_pkg::DIR_RESET;
      end
      else if (run && (op_q == sxs_pkg::OP_LOAD_DIR))
      begin
         // Other operand values are ignored
         if (lit_q == sxs_pkg::DIR_SEL_A)
            dir_a_q <= acc_q;
         if (lit_q == sxs_pkg::DIR_SEL_B)
            dir_b_q <= acc_q;
         if (lit_q == sxs_pkg::DIR_SEL_C)
            dir_c_q <= acc_q;
      end
      else if (wr_en)
      begin
         // Software write to one direction register
         if (paddr == sxs_pkg::ADDR_DIR_A)
            dir_a_q <= pwdata[7:0];
         if (paddr == sxs_pkg::ADDR_DIR_B)
            dir_b_q <= pwdata[7:0];
         if (paddr == sxs_pkg::ADDR_DIR_C)
            dir_c_q <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog counter and prescaler
   sxs_watchdog u_wdog
   (
      .pclk(pclk),
      .presetn(presetn),
      .clear(wdog_clear),
      .count_q(wdog_count),
      .expire(wdog_expire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Power status bits and sleep state; sleep wins over wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timeout_status_bit_q <= 1'b1;
         powerdown_status_bit_q <= 1'b1;
         sleep_q <= 1'b0;
      end
      else if (wdog_clear)
      begin
         timeout_status_bit_q <= 1'b1;
         powerdown_status_bit_q <= 1'b0;
         sleep_q <= 1'b1;
      end
      else
      begin
         // Watchdog expiry pulls the active-low timeout bit down
         if (wdog_expire)
            timeout_status_bit_q <= 1'b0;
         // Wake request leaves sleep
         if (wake_req)
            sleep_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign port_a_direction = dir_a_q;
   assign port_b_direction = dir_b_q;
   assign port_c_direction = dir_c_q;
   assign osc_stop = sleep_q;
endmodule : sxs_core

// *** rtl/sxs_pkg.sv ***
/*
 * Shared constants for the subtract / xor / swap execution block:
 * register offsets, status bit positions, command fields, reset values.
 * Assumes a 32-bit APB slave and an 8-bit core datapath.
 */
package sxs_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_FILE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_DIR_A = 8'h10;
   localparam logic [7:0] ADDR_DIR_B = 8'h14;
   localparam logic [7:0] ADDR_DIR_C = 8'h18;
   localparam logic [7:0] ADDR_WDOG = 8'h1C;
   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DEST_BIT = 4;
   localparam int CMD_LIT_LSB = 8;
   // Status bit positions
   localparam int ST_CARRY = 0;
   localparam int ST_NIBBLE = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_POWERDOWN = 3;
   localparam int ST_TIMEOUT = 4;
   localparam int ST_SLEEP = 5;
   // Direction operand selectors
   localparam logic [7:0] DIR_SEL_A = 8'h05;
   localparam logic [7:0] DIR_SEL_B = 8'h06;
   localparam logic [7:0] DIR_SEL_C = 8'h07;
   // Reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] FILE_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] WDOG_ZERO = 8'h00;

   // Operations carried by the command word
   typedef enum logic [3:0] {
      OP_NONE,
      OP_LIT_SUB,
      OP_FILE_SUB,
      OP_FILE_SUB_BORROW,
      OP_NIBBLE_SWAP,
      OP_XOR_LIT,
      OP_XOR_FILE,
      OP_LOAD_DIR,
      OP_SLEEP
   } sxs_op_t;

   // Adds a + b + cin, returns 9 bits with carry out on top
   function automatic logic [8:0] sxs_add9(input logic [7:0] a, input logic [7:0] b, input logic cin);
      sxs_add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   endfunction : sxs_add9

   // Adds two nibbles + cin, returns 5 bits with nibble carry on top
   function automatic logic [4:0] sxs_add5(input logic [3:0] a, input logic [3:0] b, input logic cin);
      sxs_add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction : sxs_add5
endpackage : sxs_pkg

// *** rtl/sxs_alu.sv ***
/*
 * Combinational datapath for the subtract, xor and swap operations.
 * Assumes operands are stable for the cycle in which the caller samples it.
 */
`timescale 1ns/1ps
module sxs_alu
(
   // Operation and operands
   input wire sxs_pkg::sxs_op_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] file,
   input wire logic [7:0] lit,
   input wire logic carry_in,
   // Results
   output logic [7:0] result,
   output logic carry_out,
   output logic nibble_out,
   output logic zero_out,
   output logic arith_upd,
   output logic zero_upd
);
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] minuend;
   logic cin;

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection: subtract is minuend + ~acc + cin
   always_comb
   begin
      minuend = file;
      cin = 1'b1;
      if (op == sxs_pkg::OP_LIT_SUB)
      begin
         minuend = lit;
      end
      if (op == sxs_pkg::OP_FILE_SUB_BORROW)
      begin
         // Inverted borrow is the carry itself
         cin = carry_in;
      end
   end

   assign sum9 = sxs_pkg::sxs_add9(minuend, ~acc, cin);
   assign sum5 = sxs_pkg::sxs_add5(minuend[3:0], ~acc[3:0], cin);

   ////////////////////////////////////////////////////////////////////////////
   // Result and flag update selection
   always_comb
   begin
      result = 8'h00;
      arith_upd = 1'b0;
      zero_upd = 1'b0;
      case (op)
         sxs_pkg::OP_LIT_SUB, sxs_pkg::OP_FILE_SUB, sxs_pkg::OP_FILE_SUB_BORROW:
         begin
            result = sum9[7:0];
            arith_upd = 1'b1;
            zero_upd = 1'b1;
         end
         sxs_pkg::OP_NIBBLE_SWAP:
         begin
            result = {file[3:0], file[7:4]};
         end
         sxs_pkg::OP_XOR_LIT:
         begin
            result = acc ^ lit;
            zero_upd = 1'b1;
         end
         sxs_pkg::OP_XOR_FILE:
         begin
            result = acc ^ file;
            zero_upd = 1'b1;
         end
         default:
         begin
            result = acc;
         end
      endcase
   end

   // No borrow means carry set, per nibble too
   assign carry_out = sum9[8];
   assign nibble_out = sum5[4];
   assign zero_out = (result == 8'h00);
endmodule : sxs_alu

// *** rtl/sxs_watchdog.sv ***
/*
 * Watchdog counter with an 8-bit prescaler.
 * Assumes one core clock; a clear pulse zeroes both stages.
 */
`timescale 1ns/1ps
module sxs_watchdog
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic clear,
   // State
   output logic [7:0] count_q,
   output logic expire
);
   logic [7:0] presc_q;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler then counter; clear empties both
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc_q <= 8'h00;
         count_q <= 8'h00;
      end
      else if (clear)
      begin
         presc_q <= 8'h00;
         count_q <= 8'h00;
      end
      else
      begin
         presc_q <= presc_q + 8'h01;
         if (presc_q == 8'hFF)
         begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   // Expiry when both stages wrap together
   assign expire = !clear && (presc_q == 8'hFF) && (count_q == 8'hFF);
endmodule : sxs_watchdog

// *** tb/sxs_host.sv ***
/*
 * Decoder-side model: APB master and wake source for the execution block.
 * Assumes nothing of the wait states: it waits on pready for as long as it
 * takes, and the bench's own watchdog ends a hang.
 */
`timescale 1ns/1ps
module sxs_host
(
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Wake source
   output logic wake_req
);
   // Idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wake_req = 1'b0;
   end

   // One transfer, then one idle cycle before the next can start
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Request stands until pready is seen high at an edge
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      // Released lines stop showing old values
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask : xfer

   // Single-cycle wake pulse
   task automatic wake();
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      @(posedge pclk);
   endtask : wake
endmodule : sxs_host

// *** tb/sxs_core_assertions.sv ***
/*
 * Port checker for the execution block.
 * Assumes it is bound to sxs_core on the single core clock.
 */
`timescale 1ns/1ps
module sxs_core_chk
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core side
   input wire logic wake_req,
   input wire logic [7:0] port_a_direction,
   input wire logic [7:0] port_b_direction,
   input wire logic [7:0] port_c_direction,
   input wire logic osc_stop
);
   // Completed command write
   logic cmd_wr;
   assign cmd_wr = psel & penable & pwrite & pready & (paddr == sxs_pkg::ADDR_CMD);
   // Completed write to any register; each direction check adds its own address
   logic dir_wr;
   assign dir_wr = psel & penable & pwrite & pready;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ready_one: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_drop: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   chk_err_unmap: assert property (psel && !penable && paddr > 8'h1C |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   chk_dir_a_cause: assert property ($changed(port_a_direction) |->
      $past(dir_wr && paddr == sxs_pkg::ADDR_DIR_A) || $past(cmd_wr && pwdata[15:8] == 8'h05 && pwdata[3:0] == 4'h7, 2))
      else $error("direction A changed without cause");
   chk_dir_b_cause: assert property ($changed(port_b_direction) |->
      $past(dir_wr && paddr == sxs_pkg::ADDR_DIR_B) || $past(cmd_wr && pwdata[15:8] == 8'h06 && pwdata[3:0] == 4'h7, 2))
      else $error("direction B changed without cause");
   chk_dir_c_cause: assert property ($changed(port_c_direction) |->
      $past(dir_wr && paddr == sxs_pkg::ADDR_DIR_C) || $past(cmd_wr && pwdata[15:8] == 8'h07 && pwdata[3:0] == 4'h7, 2))
      else $error("direction C changed without cause");
   chk_osc_cause: assert property ($rose(osc_stop) |-> $past(cmd_wr && pwdata[3:0] == 4'h8, 2))
      else $error("oscillator stopped without sleep");
   chk_wake_clear: assert property (osc_stop && wake_req |=> !osc_stop)
      else $error("wake did not leave sleep");

   cov_sleep: cover property ($rose(osc_stop));
   cov_dir_b: cover property ($changed(port_b_direction));
   cov_unmap: cover property (pready && pslverr);
endmodule : sxs_core_chk

bind sxs_core sxs_core_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wake_req(wake_req), .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
   .port_c_direction(port_c_direction), .osc_stop(osc_stop));

// *** tb/testbench.sv ***
/*
 * Self-checking bench: integer model of accumulator, file, flags, directions.
 * Assumes sxs_host as APB master and 250 MHz core clock.
 */
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_req, osc_stop, e;
   logic [7:0] paddr, port_a_direction, port_b_direction, port_c_direction;
   logic [31:0] pwdata, prdata, q;
   int bad_count, total_checks, acc, fil, cf, dcf, zf, pwr_down, sl, r, op;
   int dir [3];

   // 4 ns clock
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   sxs_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake_req(wake_req), .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
      .port_c_direction(port_c_direction), .osc_stop(osc_stop));
   sxs_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_req(wake_req));

   ////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0, q, e);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q, e);
   endtask : wr

   // Subtraction as add of inverse with carry in
   task automatic sub(input int a, input int b, input int ci);
      r = a + (~b & 255) + ci;
      cf = r >> 8;
      dcf = ((a & 15) + (~b & 15) + ci) >> 4;
      r = r & 255;
      zf = (r == 0);
   endtask : sub

   // Load operands and writable flags
   task automatic load(input int a, input int f, input int st);
      acc = a;
      fil = f;
      cf = st & 1;
      dcf = (st >> 1) & 1;
      zf = (st >> 2) & 1;
      wr(sxs_pkg::ADDR_ACC, 32'(a));
      wr(sxs_pkg::ADDR_FILE, 32'(f));
      wr(sxs_pkg::ADDR_STATUS, 32'(st));
   endtask : load

   // Issue one command and update the model
   task automatic run(input int o, input int d, input int k);
      wr(sxs_pkg::ADDR_CMD, 32'((k << 8) | (d << 4) | o));
      if (sl != 0)
         o = 0;
      if (o == 1 || o == 5)
         d = 0;
      case (o)
         1: sub(k, acc, 1);
         2: sub(fil, acc, 1);
         3: sub(fil, acc, cf);
         4: r = ((fil & 15) << 4) | (fil >> 4);
         5: r = acc ^ k;
         6: r = acc ^ fil;
         7: if (k >= 5 && k <= 7) dir[k - 5] = acc;
         8: begin pwr_down = 0; sl = 1; end
         default: r = 0;
      endcase
      if (o == 5 || o == 6)
         zf = (r == 0);
      if (o >= 1 && o <= 6 && d != 0)
         fil = r;
      else if (o >= 1 && o <= 6)
         acc = r;
   endtask : run

   task automatic verify();
      rd(sxs_pkg::ADDR_ACC);
      chk("acc", q, 32'(acc));
      rd(sxs_pkg::ADDR_FILE);
      chk("file", q, 32'(fil));
      rd(sxs_pkg::ADDR_STATUS);
      chk("status", q, 32'(cf | dcf << 1 | zf << 2 | pwr_down << 3 | 16 | sl << 5));
      chk("dir_a", 32'(port_a_direction), 32'(dir[0]));
      chk("dir_b", 32'(port_b_direction), 32'(dir[1]));
      chk("dir_c", 32'(port_c_direction), 32'(dir[2]));
      chk("osc_stop", 32'(osc_stop), 32'(sl));
   endtask : verify

   ////////////////////////////////////////
   // Hang guard
   initial
   begin
      #80000;
      bad_count++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      presetn = 1'b0;
      bad_count = 0;
      total_checks = 0;
      {acc, fil, cf, dcf, zf, sl} = '0;
      pwr_down = 1;
      dir = '{255, 255, 255};
      void'($urandom(6534));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      verify();
      rd(8'h24);
      chk("unmapped_data", q, 32'h0);
      chk("unmapped_err", 32'(e), 32'h1);
      // Equal operands: zero results for the subtract and xor forms, no borrow for the subtract forms
      for (op = 1; op <= 7; op++)
      begin
         load(8'h3C, 8'h3C, op);
         run(op, op & 1, (op == 7) ? 6 : 8'h3C);
         verify();
      end
      repeat (60)
      begin
         op = 1 + $urandom % 7;
         load($urandom % 256, $urandom % 256, $urandom);
         run(op, $urandom % 2, (op == 7) ? 4 + $urandom % 5 : $urandom % 256);
         verify();
      end
      // Sleep, refused command, wake
      run(8, 0, 0);
      verify();
      rd(sxs_pkg::ADDR_WDOG);
      chk("watchdog", q, 32'h0);
      load(8'h55, 8'h0F, 0);
      run(5, 0, 8'hFF);
      verify();
      i_host.wake();
      sl = 0;
      run(5, 0, 8'hFF);
      verify();
      complete_run();
   end
endmodule : testbench
